// ==== fsol_defs.vh ====
// fsol_defs.vh: constants for the flash status and option load block
// assumes inclusion by fsol_flash_status.v only
`ifndef FSOL_DEFS_VH
`define FSOL_DEFS_VH
`define FSOL_ADDR_STATE      12'hFF8
`define FSOL_STATE_RESET     8'h00
`define FSOL_CODE_LOCKED     6'h00
`define FSOL_CODE_FIRST      6'h01
`define FSOL_CODE_UNLOCKED   6'h02
`define FSOL_CODE_PROGRAM    6'h08
`define FSOL_CODE_PAGE_ERASE 6'h10
`define FSOL_CODE_MASS_ERASE 6'h20
`define FSOL_CMD_UNLOCK1     8'h73
`define FSOL_CMD_UNLOCK2     8'h8C
`define FSOL_CMD_PAGE_ERASE  8'h95
`define FSOL_CMD_MASS_ERASE  8'h63
`define FSOL_CMD_PROGRAM     8'h01
`define FSOL_PAGE_BYTES      512
`define FSOL_ROW_BYTES       64
`define FSOL_ROWS_PER_PAGE   8
`define FSOL_ADDR_W          16
`define FSOL_HIGH_SECT_BASE  16'hE000
`define FSOL_OPT_ADDR_USER   16'h0000
`define FSOL_OPT_ADDR_RSVD   16'h0001
`define FSOL_OPT_WDT_IRQ     0
`define FSOL_OPT_WDT_ON      1
`define FSOL_OPT_RD_PROT     2
`define FSOL_OPT_WR_PROT     3
`define FSOL_OPT_HS_PROT     4
`define FSOL_OPT_RESET       8'hFF
`endif

// ==== fsol_flash_status.v ====
// fsol_flash_status.v: flash controller state, unlock tracking, option byte load
// assumes a register-file port on mclk_i and a flash read/write engine outside
`timescale 1ns/1ps
`include "fsol_defs.vh"
// What this block does
// - an erase clears at least one whole 512-byte page
// - each page holds eight rows of 64 bytes
// - high sector write/erase permission is separate from the rest
// - program and erase come from core or debugger in circuit
// - state register readable any time; writes there go to control
// - state codes: locked 0, first unlock 1, unlocked 2
// - upper bits 001 program, 010 page erase, 100 mass erase
// - top two bits of the state register read zero
// - every reset kind loads option bytes into option registers
// - options applied on the same clock edge that reset is released to the core
// - option registers are not reachable from the register file
// - user option byte comes from program address zero
// - option byte picks watchdog response, watchdog enable, read and write protection
module fsol_flash_status (
   input  wire        mclk_i,
   input  wire        rst_i,
   input  wire        short_rst_i,
   input  wire        stop_recover_i,
   input  wire [11:0] rf_addr_i,
   input  wire [7:0]  rf_wdata_i,
   input  wire        rf_wr_i,
   input  wire        rf_rd_i,
   input  wire        dbg_sel_i,
   input  wire [6:0]  page_sel_i,
   input  wire [7:0]  mem_rdata_i,
   input  wire        op_done_i,
   output reg  [7:0]  rf_rdata_o,
   output reg  [15:0] mem_addr_o,
   output reg         mem_rd_o,
   output reg         erase_page_o,
   output reg         erase_mass_o,
   output reg         prog_en_o,
   output reg  [15:0] erase_base_o,
   output reg         hs_write_ok_o,
   output reg         main_write_ok_o,
   output reg         core_hold_o,
   output reg         wdt_irq_sel_o,
   output reg         wdt_en_o,
   output reg         rd_protect_o,
   output reg         op_from_dbg_o
);
   localparam S_LOAD_REQ  = 2'b00;
   localparam S_LOAD_WAIT = 2'b01;
   localparam S_LOAD_TAKE = 2'b10;
   localparam S_RUN       = 2'b11;

   reg [1:0] load_state;
   reg [5:0] ctrl_code;
   reg [7:0] opt_byte;
   reg       short_s1;
   reg       short_s2;
   reg       stop_s1;
   reg       stop_s2;
   reg [5:0] next_code;
   wire      wr_ctrl;
   wire      any_reload;
   wire      busy;
   wire      start_page;
   wire      start_mass;
   wire      run_prog;

   assign wr_ctrl    = rf_wr_i && (rf_addr_i == `FSOL_ADDR_STATE);
   assign any_reload = short_s2 || stop_s2;
   assign busy       = ctrl_code[5] || ctrl_code[4] || ctrl_code[3];
   assign start_page = (next_code == `FSOL_CODE_PAGE_ERASE) && !busy;
   assign start_mass = (next_code == `FSOL_CODE_MASS_ERASE) && !busy;
   assign run_prog   = next_code[3] && !core_hold_o;

   // unlock sequence and operation tracking
   always @* begin
      next_code = ctrl_code;
      if (busy) begin
         if (op_done_i)
            next_code = `FSOL_CODE_LOCKED;
      end else if (wr_ctrl) begin
         case (ctrl_code)
            `FSOL_CODE_LOCKED:
               next_code = (rf_wdata_i == `FSOL_CMD_UNLOCK1) ?
                           `FSOL_CODE_FIRST : `FSOL_CODE_LOCKED;
            `FSOL_CODE_FIRST:
               next_code = (rf_wdata_i == `FSOL_CMD_UNLOCK2) ?
                           `FSOL_CODE_UNLOCKED : `FSOL_CODE_LOCKED;
            `FSOL_CODE_UNLOCKED: begin
               if (rf_wdata_i == `FSOL_CMD_PAGE_ERASE)
                  next_code = `FSOL_CODE_PAGE_ERASE;
               else if (rf_wdata_i == `FSOL_CMD_MASS_ERASE)
                  next_code = `FSOL_CODE_MASS_ERASE;
               else if (rf_wdata_i == `FSOL_CMD_PROGRAM)
                  next_code = `FSOL_CODE_PROGRAM;
               else
                  next_code = `FSOL_CODE_LOCKED;
            end
            default:
               next_code = `FSOL_CODE_LOCKED;
         endcase
      end
   end

   // short reset request is a pin, so synchronise it
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         short_s1 <= 1'b0;
         short_s2 <= 1'b0;
      end else begin
         short_s1 <= short_rst_i;
         short_s2 <= short_s1;
      end
   end

   // stop-mode recovery is a pin as well
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         stop_s1 <= 1'b0;
         stop_s2 <= 1'b0;
      end else begin
         stop_s1 <= stop_recover_i;
         stop_s2 <= stop_s1;
      end
   end

   // option byte load runs after every reset kind
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         load_state  <= S_LOAD_REQ;
         opt_byte    <= `FSOL_OPT_RESET;
         core_hold_o <= 1'b1;
         mem_rd_o    <= 1'b0;
         mem_addr_o  <= `FSOL_OPT_ADDR_USER;
      end else if (any_reload) begin
         load_state  <= S_LOAD_REQ;
         core_hold_o <= 1'b1;
         mem_rd_o    <= 1'b0;
      end else begin
         case (load_state)
            S_LOAD_REQ: begin
               mem_addr_o <= `FSOL_OPT_ADDR_USER;
               mem_rd_o   <= 1'b1;
               load_state <= S_LOAD_WAIT;
            end
            S_LOAD_WAIT: begin
               mem_rd_o   <= 1'b0;
               load_state <= S_LOAD_TAKE;
            end
            S_LOAD_TAKE: begin
               opt_byte   <= mem_rdata_i;
               load_state <= S_RUN;
            end
            S_RUN:
               core_hold_o <= 1'b0;
            default:
               load_state <= S_LOAD_REQ;
         endcase
      end
   end

   // controller state code; held locked while options load
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_code <= `FSOL_CODE_LOCKED;
      end else if (core_hold_o) begin
         ctrl_code <= `FSOL_CODE_LOCKED;
      end else begin
         ctrl_code <= next_code;
      end
   end

   // read port: status at its own address, zero elsewhere
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rf_rdata_o <= `FSOL_STATE_RESET;
      end else if (rf_rd_i && rf_addr_i == `FSOL_ADDR_STATE) begin
         rf_rdata_o <= {2'b00, ctrl_code};
      end else begin
         rf_rdata_o <= 8'h00;
      end
   end

   // erase and program strobes toward the flash engine
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         erase_page_o  <= 1'b0;
         erase_mass_o  <= 1'b0;
         prog_en_o     <= 1'b0;
         erase_base_o  <= 16'h0000;
         op_from_dbg_o <= 1'b0;
      end else begin
         erase_page_o <= start_page;
         erase_mass_o <= start_mass;
         prog_en_o    <= run_prog;
         erase_base_o <= {page_sel_i, 9'h000};
         if (wr_ctrl && !busy)
            op_from_dbg_o <= dbg_sel_i;
      end
   end

   // watchdog options follow the loaded option byte
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wdt_irq_sel_o <= 1'b0;
         wdt_en_o      <= 1'b0;
      end else begin
         wdt_irq_sel_o <= opt_byte[`FSOL_OPT_WDT_IRQ];
         wdt_en_o      <= opt_byte[`FSOL_OPT_WDT_ON];
      end
   end

   // read and write protection options
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_protect_o    <= 1'b0;
         main_write_ok_o <= 1'b0;
         hs_write_ok_o   <= 1'b0;
      end else begin
         rd_protect_o    <= !opt_byte[`FSOL_OPT_RD_PROT];
         main_write_ok_o <= opt_byte[`FSOL_OPT_WR_PROT];
         hs_write_ok_o   <= opt_byte[`FSOL_OPT_HS_PROT];
      end
   end
endmodule

// ==== fsol_monitor.sv ====
// fsol_monitor.sv: assertions on the flash status block ports
// assumes binding to fsol_flash_status
`timescale 1ns/1ps
module fsol_monitor (
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic [11:0] rf_addr_i,
   input wire logic        rf_rd_i,
   input wire logic [7:0]  rf_wdata_i,
   input wire logic [7:0]  mem_rdata_i,
   input wire logic [7:0]  rf_rdata_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic        mem_rd_o,
   input wire logic        erase_page_o,
   input wire logic [15:0] erase_base_o,
   input wire logic        core_hold_o,
   input wire logic        wdt_en_o,
   input wire logic        rd_protect_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_top; rf_rdata_o[7:6] == 2'h0; endproperty
   a_top: assert property (p_top) else $error("top bits set");
   property p_rd0; rf_rd_i && rf_addr_i != 12'hFF8 |=> rf_rdata_o == 8'h00; endproperty
   a_rd0: assert property (p_rd0) else $error("foreign read data");
   property p_ers;
      $rose(erase_page_o) |-> $past(rf_wdata_i) == 8'h95 || $past(rf_wdata_i, 2) == 8'h95;
   endproperty
   a_ers: assert property (p_ers) else $error("stray page erase");
   property p_base; erase_base_o[8:0] == 9'h000; endproperty
   a_base: assert property (p_base) else $error("erase base off page");
   property p_hold; $fell(rst_i) |-> core_hold_o [*3] ##[1:4] !core_hold_o; endproperty
   a_hold: assert property (p_hold) else $error("core hold timing");
   property p_load; $fell(rst_i) |-> ##[0:2] mem_rd_o; endproperty
   a_load: assert property (p_load) else $error("no option read");
   property p_addr; mem_rd_o |-> mem_addr_o == 16'h0000; endproperty
   a_addr: assert property (p_addr) else $error("option address");
   property p_opt;
      $fell(mem_rd_o) |-> ##2 (wdt_en_o == $past(mem_rdata_i[1], 2) &&
                               rd_protect_o == !$past(mem_rdata_i[2], 2));
   endproperty
   a_opt: assert property (p_opt) else $error("option not applied");
endmodule
bind fsol_flash_status fsol_monitor u_mon (
   .mclk_i       (mclk_i),
   .rst_i        (rst_i),
   .rf_addr_i    (rf_addr_i),
   .rf_rd_i      (rf_rd_i),
   .rf_wdata_i   (rf_wdata_i),
   .mem_rdata_i  (mem_rdata_i),
   .rf_rdata_o   (rf_rdata_o),
   .mem_addr_o   (mem_addr_o),
   .mem_rd_o     (mem_rd_o),
   .erase_page_o (erase_page_o),
   .erase_base_o (erase_base_o),
   .core_hold_o  (core_hold_o),
   .wdt_en_o     (wdt_en_o),
   .rd_protect_o (rd_protect_o)
);

// ==== fsol_prog_mem.sv ====
// fsol_prog_mem.sv: program memory model for the option load
// assumes data sampled two cycles after the read strobe
`timescale 1ns/1ps
module fsol_prog_mem (
   input  wire logic        mclk_i,
   input  wire logic        mem_rd_i,
   input  wire logic [15:0] mem_addr_i,
   input  wire logic [7:0]  opt_i,
   output wire logic [7:0]  mem_rdata_o
);
   logic [1:0] live = 2'h0;
   logic       rsvd = 1'b0;
   always @(posedge mclk_i) begin
      live <= {live[0], mem_rd_i};
      if (mem_rd_i) rsvd <= mem_addr_i[0];
   end
   // option byte at zero, reserved byte erased, stale data inverted
   assign mem_rdata_o = |live ? (rsvd ? 8'hFF : opt_i) : ~opt_i;
endmodule

// ==== test_fsol_flash_status.sv ====
// test_fsol_flash_status.sv: self-checking bench for the flash status block
// assumes fsol_prog_mem answers the option reads
`timescale 1ns/1ps
module test_fsol_flash_status;
   logic mclk_i = 0, rst_i = 1, short_rst_i = 0, stop_recover_i = 0, rd_d = 0;
   logic rf_wr_i = 0, rf_rd_i = 0, dbg_sel_i = 0, op_done_i = 0;
   logic [11:0] rf_addr_i = 0;
   logic [7:0]  rf_wdata_i = 0, mem_rdata_i, rf_rdata_o, opt = 8'hFF;
   logic [6:0]  page_sel_i = 0;
   logic [15:0] mem_addr_o, erase_base_o;
   logic mem_rd_o, erase_page_o, erase_mass_o, prog_en_o, hs_write_ok_o, main_write_ok_o;
   logic core_hold_o, wdt_irq_sel_o, wdt_en_o, rd_protect_o, op_from_dbg_o;
   logic [16:0] lf = 17'd96043;
   logic [7:0]  q[$];
   logic [7:0]  cm[3] = '{8'h95, 8'h63, 8'h01};
   logic [7:0]  ex[3] = '{8'h10, 8'h20, 8'h08};
   int fail_count = 0, checks_done = 0;
   fsol_flash_status DUT (
      .mclk_i          (mclk_i),
      .rst_i           (rst_i),
      .short_rst_i     (short_rst_i),
      .stop_recover_i  (stop_recover_i),
      .rf_addr_i       (rf_addr_i),
      .rf_wdata_i      (rf_wdata_i),
      .rf_wr_i         (rf_wr_i),
      .rf_rd_i         (rf_rd_i),
      .dbg_sel_i       (dbg_sel_i),
      .page_sel_i      (page_sel_i),
      .mem_rdata_i     (mem_rdata_i),
      .op_done_i       (op_done_i),
      .rf_rdata_o      (rf_rdata_o),
      .mem_addr_o      (mem_addr_o),
      .mem_rd_o        (mem_rd_o),
      .erase_page_o    (erase_page_o),
      .erase_mass_o    (erase_mass_o),
      .prog_en_o       (prog_en_o),
      .erase_base_o    (erase_base_o),
      .hs_write_ok_o   (hs_write_ok_o),
      .main_write_ok_o (main_write_ok_o),
      .core_hold_o     (core_hold_o),
      .wdt_irq_sel_o   (wdt_irq_sel_o),
      .wdt_en_o        (wdt_en_o),
      .rd_protect_o    (rd_protect_o),
      .op_from_dbg_o   (op_from_dbg_o)
   );
   fsol_prog_mem u_mem (
      .mclk_i      (mclk_i),
      .mem_rd_i    (mem_rd_o),
      .mem_addr_i  (mem_addr_o),
      .opt_i       (opt),
      .mem_rdata_o (mem_rdata_i)
   );
   initial forever #5 mclk_i = ~mclk_i;
   function automatic [16:0] nx(input [16:0] s);
      nx = {s[15:0], s[16] ^ s[13]};
   endfunction
   task automatic chk(input [15:0] seen, input [15:0] exp, input string nm);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      rf_addr_i <= a;
      rf_wdata_i <= d;
      rf_wr_i <= w;
      rf_rd_i <= !w;
      page_sel_i <= lf[6:0];
      dbg_sel_i <= lf[8];
      lf = nx(lf);
      if (!w) q.push_back(d);
      @(posedge mclk_i);
      rf_wr_i <= 0;
      rf_rd_i <= 0;
   endtask
   task automatic boot(input int k);
      opt = lf[7:0];
      lf = nx(lf);
      @(posedge mclk_i);
      rst_i <= k == 0;
      short_rst_i <= k == 1;
      stop_recover_i <= k == 2;
      repeat (k == 0 ? 19 : 3) @(posedge mclk_i);
      {rst_i, short_rst_i, stop_recover_i} <= 3'h0;
      repeat (3) @(posedge mclk_i);
      chk(core_hold_o, 1, "hold set");
      for (int i = 0; i < 50 && core_hold_o !== 1'b0; i++) @(posedge mclk_i);
      chk(core_hold_o, 0, "hold");
      chk({wdt_irq_sel_o, wdt_en_o, rd_protect_o}, {opt[0], opt[1], !opt[2]}, "opts");
      chk({main_write_ok_o, hs_write_ok_o}, {opt[3], opt[4]}, "write enables");
   endtask
   always @(posedge mclk_i) begin
      rd_d <= rf_rd_i;
      #1 if (rd_d) chk(rf_rdata_o, q.pop_front(), "read data");
   end
   initial begin
      boot(0);
      acc(0, 12'hFF8, 8'h00);
      acc(0, {4'h7, lf[7:0]}, 8'h00);
      foreach (cm[i]) begin
         acc(1, 12'hFF8, 8'h73);
         acc(0, 12'hFF8, 8'h01);
         acc(1, 12'hFF8, 8'h8C);
         acc(0, 12'hFF8, 8'h02);
         acc(1, 12'hFF8, cm[i]);
         #1 chk({erase_mass_o, erase_page_o, prog_en_o}, ex[i][5:3], "strobes");
         chk(op_from_dbg_o, dbg_sel_i, "source");
         chk(erase_base_o, {page_sel_i, 9'h000}, "erase base");
         acc(1, 12'hFF8, 8'h73);
         #1 chk({erase_mass_o, erase_page_o, prog_en_o}, {2'b00, ex[i][3]}, "pulse");
         acc(0, 12'hFF8, ex[i]);
         @(posedge mclk_i) op_done_i <= 1;
         @(posedge mclk_i) op_done_i <= 0;
         acc(0, 12'hFF8, 8'h00);
      end
      acc(1, 12'hFF8, 8'h73);
      acc(1, 12'hFF8, 8'h95);
      acc(0, 12'hFF8, 8'h00);
      boot(1);
      boot(2);
      final_report;
   end
   initial begin
      repeat (5000) @(posedge mclk_i);
      fail_count++;
      final_report;
   end
endmodule
